// >>> src/uwic_top.sv
// Serial wake-up, clock-stop freeze and infrared carrier modulation
// Summary of operation
// R1: While the system clock is stopped a transmission freezes and resumes from the same point.
// R2: While the system clock is stopped a reception freezes and resumes from the same point.
// R3: Idle or sleep entry leaves every serial register unchanged.
// R4: Software should let transfers finish before it enters idle or sleep.
// R5: With wake, unit, receiver and receive-irq enables set, a falling receive edge wakes the part.
// R6: Receive data during the post-wake start-up period is discarded.
// R7: A wake interrupt is raised only if global and serial irq enables are set too.
// R8: The wake interrupt waits until the start-up period has fully elapsed.
// R9: With modulation on, the carrier appears only while the transmitted bit is 0.
// R10: Bit 7 of the carrier control register selects output polarity.
// R11: The carrier frequency is the system clock over coefficient plus one, halved.
// R12: Bit 0 of the modulation switch turns carrier modulation on or off.
// R13: Bits 7 to 1 of the modulation switch read as zero.
// R14: A counter toggles a square wave every coefficient-plus-one cycles.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps

module uwic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [CW-1:0]    cnt_ff;
  logic [AW-1:0]    nxt_wp;
  logic [AW-1:0]    nxt_rp;
  logic [CW-1:0]    nxt_cnt;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_wp  = push ? bump(wp_ff) : wp_ff;
    nxt_rp  = pop ? bump(rp_ff) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; valid is tracked by the count
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule // uwic_fifo

module uwic_top #(
  parameter int STARTUP_CYCLES = uwic_pkg::STARTUP_CYCLES,
  parameter int BAUD_DIV       = uwic_pkg::BAUD_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clk_run,
  input  wire logic        lp_mode,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic        rxd,
  output logic             txd,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             wake_req,
  output logic             wake_irq,
  output logic             startup_busy
);
  localparam int SUW = $clog2(STARTUP_CYCLES + 1);
  localparam int BW  = $clog2(BAUD_DIV + 1);
  localparam logic [BW-1:0] BAUD_LAST = BW'(BAUD_DIV - 1);
  localparam logic [BW-1:0] BAUD_HALF = BW'(BAUD_DIV / 2);

  logic [7:0]     carrier_ff, nxt_carrier;
  logic [7:0]     modsw_ff, nxt_modsw;
  logic [7:0]     wakectl_ff, nxt_wakectl;
  logic [31:0]    prdata_ff, nxt_prdata;
  logic           wr;
  logic           hit;

  // Only software writes move these; idle or sleep entry touches none (R3)
  assign wr     = psel && penable && pwrite;
  assign hit    = (paddr == uwic_pkg::OFS_CARRIER) || (paddr == uwic_pkg::OFS_MODSW)
               || (paddr == uwic_pkg::OFS_WAKECTL) || (paddr == uwic_pkg::OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_ff;

  logic uen, rxon, receive_irq_enable, wake_en, gie, sie;
  assign uen     = wakectl_ff[uwic_pkg::UEN_BIT];
  assign rxon    = wakectl_ff[uwic_pkg::RXON_BIT];
  assign receive_irq_enable     = wakectl_ff[uwic_pkg::RIE_BIT];
  assign wake_en = wakectl_ff[uwic_pkg::WAKE_BIT];
  assign gie     = wakectl_ff[uwic_pkg::GIE_BIT];
  assign sie     = wakectl_ff[uwic_pkg::SIE_BIT];

  uwic_pkg::uwic_ser_e tx_st_ff, nxt_tx_st, rx_st_ff, nxt_rx_st;
  logic [SUW-1:0] su_ff, nxt_su;

  always_comb begin
    nxt_carrier = carrier_ff;
    nxt_modsw   = modsw_ff;
    nxt_wakectl = wakectl_ff;
    nxt_prdata  = prdata_ff;
    if (wr && paddr == uwic_pkg::OFS_CARRIER) begin
      nxt_carrier = pwdata[7:0];
    end else if (wr && paddr == uwic_pkg::OFS_MODSW) begin
      // R13: upper bits not stored
      nxt_modsw = pwdata[7:0] & 8'h01;
    end else if (wr && paddr == uwic_pkg::OFS_WAKECTL) begin
      nxt_wakectl = pwdata[7:0] & uwic_pkg::WAKECTL_MASK;
    end
    // Read data is captured in the setup cycle so the access needs no wait
    if (psel && !penable && !pwrite) begin
      if (paddr == uwic_pkg::OFS_CARRIER) begin
        nxt_prdata = {24'h000000, carrier_ff};
      end else if (paddr == uwic_pkg::OFS_MODSW) begin
        nxt_prdata = {24'h000000, modsw_ff};
      end else if (paddr == uwic_pkg::OFS_WAKECTL) begin
        nxt_prdata = {24'h000000, wakectl_ff};
      end else if (paddr == uwic_pkg::OFS_STATUS) begin
        nxt_prdata = 32'h00000000;
        nxt_prdata[uwic_pkg::ST_TXBUSY]  = (tx_st_ff != uwic_pkg::SER_IDLE);
        nxt_prdata[uwic_pkg::ST_RXBUSY]  = (rx_st_ff != uwic_pkg::SER_IDLE);
        nxt_prdata[uwic_pkg::ST_STARTUP] = (su_ff != '0);
        nxt_prdata[uwic_pkg::ST_LEVEL]   = rxd;
      end else begin
        nxt_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_ff <= uwic_pkg::RST_CARRIER;
      modsw_ff   <= uwic_pkg::RST_MODSW;
      wakectl_ff <= uwic_pkg::RST_WAKECTL;
      prdata_ff  <= 32'h00000000;
    end else begin
      carrier_ff <= nxt_carrier;
      modsw_ff   <= nxt_modsw;
      wakectl_ff <= nxt_wakectl;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Transmit path: FIFO feeds an 8N1 shifter
  logic [7:0]    f_data;
  logic          f_valid, f_rd;
  logic [7:0]    tx_sh_ff, nxt_tx_sh;
  logic [2:0]    tx_bit_ff, nxt_tx_bit;
  logic [BW-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic          txb_ff, nxt_txb;

  uwic_fifo #(.WIDTH(8), .DEPTH(uwic_pkg::FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_rd)
  );

  always_comb begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_txb    = txb_ff;
    f_rd       = 1'b0;
    // R1: no clock, no progress; every field simply holds
    if (clk_run && uen) begin
      if (tx_st_ff == uwic_pkg::SER_IDLE) begin
        nxt_txb = 1'b1;
        if (f_valid) begin
          f_rd       = 1'b1;
          nxt_tx_sh  = f_data;
          nxt_tx_cnt = '0;
          nxt_txb    = 1'b0;
          nxt_tx_st  = uwic_pkg::SER_START;
        end
      end else if (tx_cnt_ff != BAUD_LAST) begin
        nxt_tx_cnt = tx_cnt_ff + 1'b1;
      end else begin
        nxt_tx_cnt = '0;
        if (tx_st_ff == uwic_pkg::SER_START) begin
          nxt_tx_st  = uwic_pkg::SER_DATA;
          nxt_tx_bit = '0;
          nxt_txb    = tx_sh_ff[0];
        end else if (tx_st_ff == uwic_pkg::SER_DATA) begin
          nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
          if (tx_bit_ff == 3'd7) begin
            nxt_tx_st = uwic_pkg::SER_STOP;
            nxt_txb   = 1'b1;
          end else begin
            nxt_tx_bit = tx_bit_ff + 1'b1;
            nxt_txb    = tx_sh_ff[1];
          end
        end else begin
          nxt_tx_st = uwic_pkg::SER_IDLE;
        end
      end
    end
  end

  // Receive path and wake detection
  logic          rx_prev_ff, nxt_rx_prev;
  logic [7:0]    rx_sh_ff, nxt_rx_sh;
  logic [2:0]    rx_bit_ff, nxt_rx_bit;
  logic [BW-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [7:0]    rx_data_ff, nxt_rx_data;
  logic          rx_valid_ff, nxt_rx_valid;
  logic          wake_ff, nxt_wake;
  logic          wirq_ff, nxt_wirq;
  logic          fall;

  assign fall = rx_prev_ff && !rxd;

  always_comb begin
    nxt_rx_prev  = rxd;
    nxt_rx_st    = rx_st_ff;
    nxt_rx_sh    = rx_sh_ff;
    nxt_rx_bit   = rx_bit_ff;
    nxt_rx_cnt   = rx_cnt_ff;
    nxt_rx_data  = rx_data_ff;
    nxt_rx_valid = 1'b0;
    nxt_wake     = 1'b0;
    nxt_wirq     = 1'b0;
    nxt_su       = su_ff;
    // R5: armed wake on a falling receive edge while in low power
    if (lp_mode && wake_en && uen && rxon && receive_irq_enable && fall && su_ff == '0) begin
      nxt_wake = 1'b1;
      nxt_su   = SUW'(STARTUP_CYCLES);
    end else if (su_ff != '0) begin
      nxt_su = su_ff - 1'b1;
      // R8: raised in the cycle after the last start-up cycle; R7: only with both enables
      if (su_ff == SUW'(1)) begin
        nxt_wirq = gie && sie;
      end
    end
    // R6: start-up period or disabled receiver drops the frame
    if (su_ff != '0 || nxt_wake || !uen || !rxon) begin
      nxt_rx_st = uwic_pkg::SER_IDLE;
    end else if (clk_run) begin
      // R2: held when the clock is stopped
      if (rx_st_ff == uwic_pkg::SER_IDLE) begin
        if (fall) begin
          nxt_rx_st  = uwic_pkg::SER_START;
          nxt_rx_cnt = '0;
        end
      end else if (rx_st_ff == uwic_pkg::SER_START) begin
        nxt_rx_cnt = rx_cnt_ff + 1'b1;
        if (rx_cnt_ff == BAUD_HALF) begin
          nxt_rx_cnt = '0;
          nxt_rx_bit = '0;
          nxt_rx_st  = rxd ? uwic_pkg::SER_IDLE : uwic_pkg::SER_DATA;
        end
      end else if (rx_cnt_ff != BAUD_LAST) begin
        nxt_rx_cnt = rx_cnt_ff + 1'b1;
      end else begin
        nxt_rx_cnt = '0;
        if (rx_st_ff == uwic_pkg::SER_DATA) begin
          nxt_rx_sh  = {rxd, rx_sh_ff[7:1]};
          nxt_rx_bit = rx_bit_ff + 1'b1;
          if (rx_bit_ff == 3'd7) begin
            nxt_rx_st = uwic_pkg::SER_STOP;
          end
        end else begin
          nxt_rx_st = uwic_pkg::SER_IDLE;
          // A low stop bit is a broken frame and is dropped
          if (rxd) begin
            nxt_rx_data  = rx_sh_ff;
            nxt_rx_valid = 1'b1;
          end
        end
      end
    end
  end

  // Carrier generator and output stage
  logic [6:0] car_cnt_ff, nxt_car_cnt;
  logic       car_ff, nxt_car;
  logic       txd_ff, nxt_txd;
  logic       pol;

  assign pol = carrier_ff[uwic_pkg::POL_BIT];

  always_comb begin
    nxt_car_cnt = car_cnt_ff;
    nxt_car     = car_ff;
    // R14: toggle after coefficient-plus-one cycles
    if (clk_run) begin
      // R11: half period is coefficient plus one
      if (car_cnt_ff >= carrier_ff[uwic_pkg::DIV_MSB:0]) begin
        nxt_car_cnt = '0;
        nxt_car     = !car_ff;
      end else begin
        nxt_car_cnt = car_cnt_ff + 1'b1;
      end
    end
    // R1: output stage freezes too, so the pin never lags a stopped clock
    nxt_txd = txd_ff;
    if (clk_run) begin
      nxt_txd = txb_ff;
      // R12: modulation switch
      if (modsw_ff[uwic_pkg::MODEN_BIT]) begin
        // R9: carrier only on low bits; R10: polarity 1 gives high bursts
        nxt_txd = txb_ff ? !pol : (pol ? car_ff : !car_ff);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff    <= uwic_pkg::SER_IDLE;
      tx_sh_ff    <= 8'h00;
      tx_bit_ff   <= 3'h0;
      tx_cnt_ff   <= '0;
      txb_ff      <= 1'b1;
      rx_st_ff    <= uwic_pkg::SER_IDLE;
      rx_prev_ff  <= 1'b1;
      rx_sh_ff    <= 8'h00;
      rx_bit_ff   <= 3'h0;
      rx_cnt_ff   <= '0;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      wake_ff     <= 1'b0;
      wirq_ff     <= 1'b0;
      su_ff       <= '0;
      car_cnt_ff  <= 7'h00;
      car_ff      <= 1'b0;
      txd_ff      <= 1'b1;
    end else begin
      tx_st_ff    <= nxt_tx_st;
      tx_sh_ff    <= nxt_tx_sh;
      tx_bit_ff   <= nxt_tx_bit;
      tx_cnt_ff   <= nxt_tx_cnt;
      txb_ff      <= nxt_txb;
      rx_st_ff    <= nxt_rx_st;
      rx_prev_ff  <= nxt_rx_prev;
      rx_sh_ff    <= nxt_rx_sh;
      rx_bit_ff   <= nxt_rx_bit;
      rx_cnt_ff   <= nxt_rx_cnt;
      rx_data_ff  <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      wake_ff     <= nxt_wake;
      wirq_ff     <= nxt_wirq;
      su_ff       <= nxt_su;
      car_cnt_ff  <= nxt_car_cnt;
      car_ff      <= nxt_car;
      txd_ff      <= nxt_txd;
    end
  end

  assign txd          = txd_ff;
  assign rx_data      = rx_data_ff;
  assign rx_valid     = rx_valid_ff;
  assign wake_req     = wake_ff;
  assign wake_irq     = wirq_ff;
  assign startup_busy = (su_ff != '0);
endmodule // uwic_top

// >>> src/uwic_pkg.sv
// Constants and types shared by the wake and infrared carrier block
package uwic_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_CARRIER = 12'h000;
  localparam logic [11:0] OFS_MODSW   = 12'h004;
  localparam logic [11:0] OFS_WAKECTL = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00c;
  // Reset values
  localparam logic [7:0] RST_CARRIER = 8'h00;
  localparam logic [7:0] RST_MODSW   = 8'h00;
  localparam logic [7:0] RST_WAKECTL = 8'h00;
  // ir_carrier_control fields
  localparam int POL_BIT = 7;
  localparam int DIV_MSB = 6;
  // ir_modulation_switch field
  localparam int MODEN_BIT = 0;
  // Wake control fields
  localparam int UEN_BIT  = 0;
  localparam int RXON_BIT = 1;
  localparam int RIE_BIT  = 2;
  localparam int WAKE_BIT = 3;
  localparam int GIE_BIT  = 4;
  localparam int SIE_BIT  = 5;
  localparam logic [7:0] WAKECTL_MASK = 8'h3f;
  // Status fields
  localparam int ST_TXBUSY  = 0;
  localparam int ST_RXBUSY  = 1;
  localparam int ST_STARTUP = 2;
  localparam int ST_LEVEL   = 3;
  // Timing counts in system clock cycles, and the transmit FIFO depth in entries
  localparam int STARTUP_CYCLES = 1024;
  localparam int BAUD_DIV       = 16;
  localparam int FIFO_DEPTH     = 4;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} uwic_ser_e;
endpackage

// >>> verification/uwic_top_monitor.sv
// Port checker for the wake and infrared carrier block
`timescale 1ns/100ps
module uwic_monitor #(
  parameter int STARTUP_CYCLES = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        clk_run,
  input wire logic        lp_mode,
  input wire logic        txd,
  input wire logic        rx_valid,
  input wire logic        wake_req,
  input wire logic        wake_irq,
  input wire logic        startup_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] busy_cnt_ff;
  logic [15:0] nxt_busy_cnt;
  always_comb nxt_busy_cnt = startup_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_ff <= 16'h0000;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  property p_unmapped; psel && penable && paddr > 12'h00c |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("no error on unmapped access");
  property p_modsw_hi;
    psel && penable && !pwrite && paddr == uwic_pkg::OFS_MODSW |-> prdata[31:1] == 31'h0;
  endproperty
  a_modsw_hi: assert property (p_modsw_hi)
    else $error("modulation switch upper bits not zero");
  property p_tx_freeze; !clk_run && !$past(clk_run) |-> $stable(txd); endproperty
  a_tx_freeze: assert property (p_tx_freeze)
    else $error("transmit output moved while clock stopped");
  property p_wake_lp; wake_req |-> $past(lp_mode); endproperty
  a_wake_lp: assert property (p_wake_lp)
    else $error("wake request outside low power");
  property p_wake_pulse; wake_req |=> !wake_req && startup_busy; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request not followed by start-up");
  property p_irq_after; wake_irq |-> !startup_busy && !wake_req; endproperty
  a_irq_after: assert property (p_irq_after)
    else $error("wake interrupt during start-up");
  property p_irq_wait; wake_req |=> (!wake_irq) [*6]; endproperty
  a_irq_wait: assert property (p_irq_wait)
    else $error("wake interrupt too early");
  property p_startup_len; busy_cnt_ff <= 16'(STARTUP_CYCLES + 1); endproperty
  a_startup_len: assert property (p_startup_len)
    else $error("start-up period too long");
  property p_rx_discard; rx_valid |-> !startup_busy; endproperty
  a_rx_discard: assert property (p_rx_discard)
    else $error("byte received during start-up");
endmodule // uwic_monitor

bind uwic_top uwic_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .clk_run(clk_run),
  .lp_mode(lp_mode), .txd(txd), .rx_valid(rx_valid), .wake_req(wake_req),
  .wake_irq(wake_irq), .startup_busy(startup_busy)
);

// >>> verification/uwic_peer.sv
// Remote serial transmitter that drives the receive line
`timescale 1ns/100ps
module uwic_peer #(
  parameter int BAUD_DIV = 16
) (
  input wire logic       pclk,
  input wire logic       go,
  input wire logic [7:0] din,
  input wire logic       stop_bit,
  output logic           rxd,
  output logic           busy
);
  logic [9:0] frame;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
  end
  // Line idles high, so a frame always opens with a falling edge
  always @(posedge pclk) begin
    if (go && !busy) begin
      frame = {stop_bit, din, 1'b0};
      busy <= 1'b1;
      for (int i = 0; i < 10; i++) begin
        rxd <= frame[i];
        repeat (BAUD_DIV) @(posedge pclk);
      end
      rxd <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule // uwic_peer

// >>> verification/uwic_wake_and_ir_carrier_tb_top.sv
// Self-checking bench for the wake and infrared carrier block
`timescale 1ns/100ps
module uwic_wake_and_ir_carrier_tb_top;
  localparam int SU = 8;
  localparam int BD = 16;
  localparam logic [7:0] TXB [4] = '{8'h3c, 8'h81, 8'h00, 8'hff};
  localparam logic [7:0] WCF [4] = '{8'h3f, 8'h0f, 8'h1f, 8'h3d};
  localparam int WREQ [4] = '{1, 1, 1, 0};
  localparam int WIRQ [4] = '{1, 0, 0, 0};
  logic        pclk, presetn, psel, penable, pwrite, clk_run, lp_mode, tx_valid, go, stop_bit;
  logic        pready, pslverr, tx_ready, rxd, txd, rx_valid, wake_req, wake_irq, sbusy, pbusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [7:0]  tx_data, rx_data, din, rx_last, b;
  logic        errq;
  int          n_fail, n_tests, n_wreq, n_wirq, n_rxv, w0, i0, r0;

  uwic_top #(.STARTUP_CYCLES(SU), .BAUD_DIV(BD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_run(clk_run), .lp_mode(lp_mode), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rxd(rxd), .txd(txd), .rx_data(rx_data), .rx_valid(rx_valid),
    .wake_req(wake_req), .wake_irq(wake_irq), .startup_busy(sbusy));
  uwic_peer #(.BAUD_DIV(BD)) u_peer (
    .pclk(pclk), .go(go), .din(din), .stop_bit(stop_bit), .rxd(rxd), .busy(pbusy));

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (wake_req === 1'b1) n_wreq++;
    if (wake_irq === 1'b1) n_wirq++;
    if (rx_valid === 1'b1) begin
      n_rxv++;
      rx_last = rx_data;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdq);
  endtask
  // Counts only cycles in which the block's clock runs
  task automatic wait_en(input int n);
    while (n > 0) begin
      @(posedge pclk);
      if (clk_run) n--;
    end
  endtask
  task automatic cap_tx(output logic [7:0] q);
    while (txd !== 1'b0) @(posedge pclk);
    wait_en(BD / 2);
    for (int i = 0; i < 8; i++) begin
      wait_en(BD);
      q[i] = txd;
    end
    wait_en(BD);
    chk("stop bit", 32'h1, {31'h0, txd});
  endtask
  task automatic gap(input int c);
    logic p;
    int   n;
    p = txd;
    while (txd === p) @(posedge pclk);
    for (int j = 0; j < 9; j++) begin
      p = txd;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (txd === p);
      if (j > 0) chk("carrier gap", 32'(c + 1), 32'(n));
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 12000);
    n_fail++;
    end_sim();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    clk_run = 1; lp_mode = 0; tx_valid = 0; tx_data = 0; go = 0; din = 0; stop_bit = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("carrier reset", uwic_pkg::OFS_CARRIER, 32'h0);
    rd("switch reset", uwic_pkg::OFS_MODSW, 32'h0);
    rd("wake reset", uwic_pkg::OFS_WAKECTL, 32'h0);
    wr(uwic_pkg::OFS_MODSW, 8'hff);
    rd("switch", uwic_pkg::OFS_MODSW, 32'h1);
    wr(uwic_pkg::OFS_CARRIER, 8'ha5);
    rd("carrier", uwic_pkg::OFS_CARRIER, 32'ha5);
    wr(uwic_pkg::OFS_WAKECTL, 8'hff);
    rd("unmapped", 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, errq});
    rd("status idle", uwic_pkg::OFS_STATUS, 32'h8);
    lp_mode <= 1'b1;
    clk_run <= 1'b0;
    repeat (20) @(posedge pclk);
    rd("carrier kept", uwic_pkg::OFS_CARRIER, 32'ha5);
    rd("wake kept", uwic_pkg::OFS_WAKECTL, 32'h3f);
    lp_mode <= 1'b0;
    wr(uwic_pkg::OFS_MODSW, 8'h00);
    wr(uwic_pkg::OFS_WAKECTL, 8'h03);
    $display("test registers done");
    // Clock held off so the queue fills and then refuses
    for (int i = 0; i < 5; i++) begin
      chk("tx_ready", 32'(i < 4), {31'h0, tx_ready});
      tx_data <= TXB[i % 4];
      tx_valid <= tx_ready;
      @(posedge pclk);
      tx_valid <= 1'b0;
      @(posedge pclk);
    end
    clk_run <= 1'b1;
    fork
      for (int i = 0; i < 4; i++) begin
        cap_tx(b);
        chk("tx byte", {24'h0, TXB[i]}, {24'h0, b});
      end
      begin
        repeat (200) @(posedge pclk);
        clk_run <= 1'b0;
        repeat (30) @(posedge pclk);
        clk_run <= 1'b1;
      end
    join
    $display("test transmit done");
    foreach (WREQ[k]) begin
      wr(uwic_pkg::OFS_CARRIER, {1'b1, 7'(2 * k)});
      wr(uwic_pkg::OFS_MODSW, 8'h01);
      repeat (2) @(posedge pclk);
      chk("idle positive", 32'h0, {31'h0, txd});
      tx_data <= 8'h00;
      tx_valid <= 1'b1;
      @(posedge pclk);
      tx_valid <= 1'b0;
      gap(2 * k);
      repeat (150) @(posedge pclk);
    end
    wr(uwic_pkg::OFS_CARRIER, 8'h00);
    repeat (2) @(posedge pclk);
    chk("idle negative", 32'h1, {31'h0, txd});
    wr(uwic_pkg::OFS_MODSW, 8'h00);
    $display("test carrier done");
    foreach (WCF[k]) begin
      wr(uwic_pkg::OFS_WAKECTL, WCF[k]);
      w0 = n_wreq;
      i0 = n_wirq;
      r0 = n_rxv;
      lp_mode <= 1'b1;
      clk_run <= 1'b0;
      din <= 8'hff;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("wake req", 32'(WREQ[k]), 32'(n_wreq - w0));
      chk("start-up busy", 32'(WREQ[k]), {31'h0, sbusy});
      lp_mode <= 1'b0;
      clk_run <= 1'b1;
      repeat (SU + 170) @(posedge pclk);
      chk("wake irq", 32'(WIRQ[k]), 32'(n_wirq - i0));
      chk("rx discarded", 32'h0, 32'(n_rxv - r0));
    end
    wr(uwic_pkg::OFS_WAKECTL, 8'h03);
    r0 = n_rxv;
    din <= 8'ha6;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (180) @(posedge pclk);
    chk("rx count", 32'h1, 32'(n_rxv - r0));
    chk("rx byte", 32'ha6, {24'h0, rx_last});
    $display("test wake and receive done");
    end_sim();
  end
endmodule // uwic_wake_and_ir_carrier_tb_top
